// ### src/fcrb_params.svh
`ifndef FCRB_PARAMS_SVH
`define FCRB_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCRB_OFS_STATE 12'h400
`define FCRB_OFS_PTR 12'h404
`define FCRB_OFS_FILLPOP 12'h424
`define FCRB_OFS_RST 12'h428

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FCRB_ST_EMPTY_BIT 0
`define FCRB_ST_FULL_BIT 8
`define FCRB_ST_HALT_BIT 16
`define FCRB_ST_BUF_EMPTY_BIT 24
`define FCRB_PTR_RD_LSB 0
`define FCRB_PTR_WR_LSB 8
`define FCRB_FILL_BIT 0
`define FCRB_POP_BIT 8
`define FCRB_RST_BIT 0

// ----------------------------------------------------------------
// reset and reserved values
// ----------------------------------------------------------------
`define FCRB_ST_RSVD 32'hFE0000FE
`define FCRB_PTR_RESET 5'h00

// ----------------------------------------------------------------
// sizes: 32 grids of 512 bytes, counted in 32-bit words
// ----------------------------------------------------------------
`define FCRB_GRIDS 32
`define FCRB_GRID_WORDS 128

`endif

// ### src/fcrb_pkg.sv
package fcrb_pkg;

  // apb request as driven by the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fcrb_apb_req_t;

  // apb answer
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fcrb_apb_rsp_t;

  // command attributes from the flash engine
  typedef struct packed {
    logic start;
    logic bypass_flow_status;
    logic [2:0] region_sel;
    logic done;
  } fcrb_cmd_t;

  typedef enum logic {
    FCRB_MODE_DMA,
    FCRB_MODE_USER
  } fcrb_mode_t;

endpackage

// ### src/fcrb_region_ctrl.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "fcrb_params.svh"

module fcrb_region_ctrl
#(
  parameter int GRIDS = `FCRB_GRIDS,
  parameter int GRID_WORDS = `FCRB_GRID_WORDS,
  parameter int DW = 32
)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire fcrb_pkg::fcrb_apb_req_t i_apb,
  output fcrb_pkg::fcrb_apb_rsp_t o_apb,
  input wire fcrb_pkg::fcrb_cmd_t i_cmd,
  input wire logic i_ecc_uncorr,
  input wire logic i_wr_valid,
  input wire logic [DW-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [DW-1:0] o_rd_data,
  input wire logic i_rd_ready
);

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DEPTH = GRIDS * GRID_WORDS;
  localparam int GW = $clog2(GRID_WORDS);
  localparam int IW = $clog2(GRIDS);
  localparam int AW = IW + GW;
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] BLK_C = CW'(GRID_WORDS);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] count;
  logic stg_valid;
  logic [DW-1:0] stg_data;
  logic halt;
  fcrb_pkg::fcrb_mode_t mode;
  logic [IW-1:0] memory_mode_write_index;
  logic [IW-1:0] memory_mode_read_index;

  logic hit;
  logic access;
  logic wr_fire;
  logic ptr_wr;
  logic fill_req;
  logic pop_req;
  logic area_soft_reset;
  logic is_user;
  logic user_start;
  logic cmd_taken;
  logic move;
  logic take;
  logic pull;
  logic [CW-1:0] avail;
  logic [CW-1:0] fill_n;
  logic [CW-1:0] pop_n;
  logic [CW-1:0] next_count;
  logic next_stg_valid;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // misaligned or unknown addresses answer with pslverr
  always_comb
  begin
    hit = 1'b1;
    unique case (i_apb.paddr)
      `FCRB_OFS_STATE, `FCRB_OFS_PTR, `FCRB_OFS_FILLPOP, `FCRB_OFS_RST:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

  // writes act only at the edge where pready is sampled high
  assign access = i_apb.psel & i_apb.penable;
  assign wr_fire = i_clk_en & access & o_apb.pready & i_apb.pwrite & hit;
  assign ptr_wr = wr_fire & (i_apb.paddr == `FCRB_OFS_PTR);
  assign fill_req = wr_fire & (i_apb.paddr == `FCRB_OFS_FILLPOP)
    & i_apb.pwdata[`FCRB_FILL_BIT] & ~is_user;
  assign pop_req = wr_fire & (i_apb.paddr == `FCRB_OFS_FILLPOP)
    & i_apb.pwdata[`FCRB_POP_BIT] & ~is_user;
  assign area_soft_reset = wr_fire & (i_apb.paddr == `FCRB_OFS_RST)
    & i_apb.pwdata[`FCRB_RST_BIT];

  // status word, reserved fields read their fixed pattern
  always_comb
  begin
    status = `FCRB_ST_RSVD;
    status[`FCRB_ST_BUF_EMPTY_BIT] = ~stg_valid;
    status[`FCRB_ST_HALT_BIT] = halt;
    status[`FCRB_ST_FULL_BIT] = (count == DEPTH_C);
    status[`FCRB_ST_EMPTY_BIT] = (count == '0);
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_apb <= '0;
    else if (i_clk_en)
    begin
      if (access & ~o_apb.pready)
      begin
        o_apb.pready <= 1'b1;
        o_apb.pslverr <= ~hit;
        o_apb.prdata <= (hit & ~i_apb.pwrite
          & (i_apb.paddr == `FCRB_OFS_STATE)) ? status : 32'h00000000;
      end
      else
        o_apb <= '0;
    end
  end

  // ----------------------------------------------------------------
  // pointer register and mode
  // ----------------------------------------------------------------
  // indices are write-only; they take effect at the next user command
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      memory_mode_write_index <= `FCRB_PTR_RESET;
      memory_mode_read_index <= `FCRB_PTR_RESET;
    end
    else if (i_clk_en & ptr_wr)
    begin
      memory_mode_write_index <= i_apb.pwdata[`FCRB_PTR_WR_LSB +: IW];
      memory_mode_read_index <= i_apb.pwdata[`FCRB_PTR_RD_LSB +: IW];
    end
  end

  assign cmd_taken = i_cmd.start & (i_cmd.region_sel == 3'h0);
  assign user_start = cmd_taken & i_cmd.bypass_flow_status;
  assign is_user = (mode == fcrb_pkg::FCRB_MODE_USER);

  // user mode lasts from a bypass command start until a done, a region reset or a region 0 start without bypass
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      mode <= fcrb_pkg::FCRB_MODE_DMA;
    else if (i_clk_en)
    begin
      if (area_soft_reset)
        mode <= fcrb_pkg::FCRB_MODE_DMA;
      else if (cmd_taken)
        mode <= user_start ? fcrb_pkg::FCRB_MODE_USER
                           : fcrb_pkg::FCRB_MODE_DMA;
      else if (i_cmd.done)
        mode <= fcrb_pkg::FCRB_MODE_DMA;
    end
  end

  // halt: an ecc event in the reset cycle still wins
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      halt <= 1'b0;
    else if (i_clk_en)
      halt <= (halt & ~area_soft_reset) | (i_ecc_uncorr & ~is_user);
  end

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  // user mode ignores full and empty, so the count stays put
  assign take = i_wr_valid & o_wr_ready;
  assign move = stg_valid & (is_user | (count != DEPTH_C));
  assign pull = (~o_rd_valid | i_rd_ready) & ~halt
    & (is_user | (count != '0));
  assign next_stg_valid = (stg_valid & ~move) | take;

  // dummy blocks clamp at the region limits rather than wrap
  always_comb
  begin
    avail = count + CW'(move & ~is_user) - CW'(pull & ~is_user);
    fill_n = '0;
    pop_n = '0;
    if (fill_req)
      fill_n = ((DEPTH_C - avail) >= BLK_C) ? BLK_C : (DEPTH_C - avail);
    if (pop_req)
      pop_n = (avail >= BLK_C) ? BLK_C : avail;
    next_count = avail + fill_n - pop_n;
  end

  // one staging word: halves input rate, keeps the ram write simple
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      stg_valid <= 1'b0;
      o_wr_ready <= 1'b1;
    end
    else if (i_clk_en)
    begin
      stg_valid <= next_stg_valid & ~area_soft_reset;
      o_wr_ready <= ~next_stg_valid | area_soft_reset;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      stg_data <= '0;
    else if (i_clk_en & take)
      stg_data <= i_wr_data;
  end

  // region storage, no reset needed for the array itself
  always_ff @(posedge i_core_clk)
  begin
    if (i_clk_en & move)
      mem[wptr] <= stg_data;
  end

  // user start aims the pointers at the chosen grids
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else if (i_clk_en)
    begin
      if (area_soft_reset)
      begin
        wptr <= '0;
        rptr <= '0;
      end
      else if (user_start)
      begin
        wptr <= {memory_mode_write_index, {GW{1'b0}}};
        rptr <= {memory_mode_read_index, {GW{1'b0}}};
      end
      else
      begin
        wptr <= wptr + AW'(move) + AW'(fill_n);
        rptr <= rptr + AW'(pull) + AW'(pop_n);
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      count <= '0;
    else if (i_clk_en)
      count <= area_soft_reset ? '0 : next_count;
  end

  // output word register, drained in order
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end
    else if (i_clk_en)
    begin
      if (area_soft_reset)
        o_rd_valid <= 1'b0;
      else if (pull)
      begin
        o_rd_valid <= 1'b1;
        o_rd_data <= mem[rptr];
      end
      else if (i_rd_ready)
        o_rd_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  buf_busy_a: assert property (
    (i_clk_en && take && !area_soft_reset) |=> !status[`FCRB_ST_BUF_EMPTY_BIT])
    else $error("staging buffer shown empty after a word was taken");

  halt_set_a: assert property (
    (i_clk_en && i_ecc_uncorr && !is_user) |=> halt)
    else $error("halt not set by ecc error in dma mode");

  halt_hold_a: assert property (
    (halt && !(i_clk_en && area_soft_reset)) |=> halt)
    else $error("halt cleared without a region reset");

  full_block_a: assert property (
    (status[`FCRB_ST_FULL_BIT] && !is_user) |-> !move)
    else $error("write into a full region");

  count_range_a: assert property (
    count <= DEPTH_C)
    else $error("region count beyond its capacity");

  empty_block_a: assert property (
    (status[`FCRB_ST_EMPTY_BIT] && !is_user) |-> !pull)
    else $error("read from an empty region");

  fill_block_a: assert property (
    (fill_req && count == '0 && !move) |=> count == BLK_C)
    else $error("fill did not add one block");

  pop_block_a: assert property (
    (pop_req && count >= 2 * BLK_C && !move && !pull)
    |=> count == $past(count) - BLK_C)
    else $error("pop did not drop one block");

  user_aim_a: assert property (
    (i_clk_en && user_start && !area_soft_reset)
    |=> (wptr[AW-1:GW] == $past(memory_mode_write_index))
        && (rptr[AW-1:GW] == $past(memory_mode_read_index))
        && is_user)
    else $error("user pointers not aimed at the chosen grids");

  soft_reset_a: assert property (
    (area_soft_reset && !i_ecc_uncorr)
    |=> !halt && count == '0 && !stg_valid && !o_rd_valid)
    else $error("region reset left state behind");

  user_ignore_a: assert property (
    (i_clk_en && is_user && !halt && !o_rd_valid && !area_soft_reset)
    |=> o_rd_valid)
    else $error("user mode read stalled on empty");

  other_region_a: assert property (
    (i_clk_en && i_cmd.start && i_cmd.region_sel != 3'h0 && !is_user
     && !area_soft_reset) |=> !is_user)
    else $error("command for another region changed the mode");

  fill_seen_c: cover property (fill_req);
  pop_seen_c: cover property (pop_req);
  halt_seen_c: cover property (halt ##1 area_soft_reset);
  user_read_c: cover property (is_user && o_rd_valid && i_rd_ready);

endmodule

// ### tb/fcrb_far_master.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: dma master streaming words into and out of the region
// ----------------------------------------------------------------
module fcrb_far_master
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd_en,
  input wire logic i_wr_ready,
  input wire logic i_rd_valid,
  input wire logic [31:0] i_rd_data,
  output logic o_wr_valid,
  output logic [31:0] o_wr_data,
  output logic o_rd_ready
);
  logic [31:0] tx_q[$];
  logic [31:0] rx_q[$];

  initial
  begin
    o_wr_valid = 1'b0;
    o_wr_data = 32'h0;
    o_rd_ready = 1'b0;
  end

  // offer held until taken; data scrambled once released
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_wr_valid <= 1'b0;
    else if (o_wr_valid && i_wr_ready)
    begin
      o_wr_valid <= 1'b0;
      o_wr_data <= ~o_wr_data;
    end
    else if (!o_wr_valid && tx_q.size() > 0 && $urandom_range(1, 0) == 1)
    begin
      o_wr_valid <= 1'b1;
      o_wr_data <= tx_q.pop_front();
    end
  end

  // random ready so the region sees stalls
  always @(posedge i_core_clk)
  begin
    o_rd_ready <= !i_sys_rst && i_rd_en && ($urandom_range(1, 0) == 1);
    if (i_rd_valid && o_rd_ready)
      rx_q.push_back(i_rd_data);
  end
endmodule

// ### tb/flash_ctrl_region_buffer_ctrl_bench.sv
`timescale 1ns/1ps
module flash_ctrl_region_buffer_ctrl_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rd_en = 1'b0;
  logic ecc = 1'b0;
  logic clk_en = 1'b1;
  fcrb_pkg::fcrb_apb_req_t apb_req = '0;
  fcrb_pkg::fcrb_apb_rsp_t apb_rsp;
  fcrb_pkg::fcrb_cmd_t cmd = '0;
  logic wr_valid, wr_ready, rd_valid, rd_ready, perr;
  logic [31:0] wr_data, rd_data, rdat;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int k;

  always #5 core_clk = ~core_clk;

  fcrb_region_ctrl i_fcrb_region_ctrl (.i_core_clk(core_clk),
    .i_sys_rst(sys_rst), .i_clk_en(clk_en), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_cmd(cmd), .i_ecc_uncorr(ecc), .i_wr_valid(wr_valid),
    .i_wr_data(wr_data), .o_wr_ready(wr_ready), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_rd_ready(rd_ready));

  fcrb_far_master i_fcrb_far_master (.i_core_clk(core_clk),
    .i_sys_rst(sys_rst), .i_rd_en(rd_en), .i_wr_ready(wr_ready),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
    .o_wr_data(wr_data), .o_rd_ready(rd_ready));

  task give_verdict;
    $display("mismatches %0d, checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // status word expected from the four flags, reserved fields set
  function logic [31:0] st(input logic e, f, h, b);
    st = 32'hFE0000FE;
    st[0] = e;
    st[8] = f;
    st[16] = h;
    st[24] = b;
  endfunction

  // one apb transfer; waits for pready, only the hang guard ends a wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    perr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task expect_state(input logic [31:0] e);
    apb(1'b0, 12'h400, 32'h0);
    check(e, rdat);
  endtask

  task pulse(input logic [5:0] c, input logic e);
    @(posedge core_clk);
    cmd <= c;
    ecc <= e;
    @(posedge core_clk);
    cmd <= '0;
    ecc <= 1'b0;
  endtask

  // hang guard: the whole run needs at most about a thousand cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      give_verdict;
    end
  end

  initial
  begin
    void'($urandom(33386));
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    expect_state(st(1, 0, 0, 1));
    apb(1'b0, 12'h408, 32'h0);
    check(32'h1, {31'h0, perr});
    apb(1'b1, 12'h424, $urandom() & 32'hFFFFFEFE);
    expect_state(st(1, 0, 0, 1));
    for (k = 0; k < 32; k++)
      apb(1'b1, 12'h424, 32'h1);
    // one word already sits in the output stage, so one slot is left
    expect_state(st(0, 0, 0, 1));
    apb(1'b1, 12'h424, 32'h1);
    expect_state(st(0, 1, 0, 1));
    apb(1'b1, 12'h424, 32'h100);
    expect_state(st(0, 0, 0, 1));
    for (k = 0; k < 31; k++)
      apb(1'b1, 12'h424, 32'h100);
    expect_state(st(1, 0, 0, 1));
    // the dummy word waiting in the output stage leaves first
    rd_en <= 1'b1;
    k = 0;
    while (i_fcrb_far_master.rx_q.size() < 1 && k < 100)
    begin
      @(posedge core_clk);
      k++;
    end
    check(32'h1, i_fcrb_far_master.rx_q.size());
    i_fcrb_far_master.rx_q.delete();
    // random stream through the fifo with stalls both sides
    for (k = 0; k < 24; k++)
    begin
      exp_q.push_back($urandom());
      i_fcrb_far_master.tx_q.push_back(exp_q[k]);
    end
    k = 0;
    while (i_fcrb_far_master.rx_q.size() < 24 && k < 500)
    begin
      @(posedge core_clk);
      k++;
    end
    foreach (exp_q[i])
      check(exp_q[i], i_fcrb_far_master.rx_q[i]);
    expect_state(st(1, 0, 0, 1));
    // halt: only the word already presented may still leave
    rd_en <= 1'b0;
    for (k = 0; k < 4; k++)
      i_fcrb_far_master.tx_q.push_back($urandom());
    repeat (40) @(posedge core_clk);
    pulse(6'h00, 1'b1);
    expect_state(st(0, 0, 1, 1));
    i_fcrb_far_master.rx_q.delete();
    rd_en <= 1'b1;
    repeat (30) @(posedge core_clk);
    check(32'h1, i_fcrb_far_master.rx_q.size());
    apb(1'b1, 12'h424, 32'h100);
    pulse(6'h01, 1'b0);
    apb(1'b1, 12'h428, 32'h0);
    expect_state(st(1, 0, 1, 1));
    apb(1'b1, 12'h428, 32'h1);
    expect_state(st(1, 0, 0, 1));
    // nonzero region select: command dropped, ecc still halts
    pulse(6'h32, 1'b1);
    expect_state(st(1, 0, 1, 1));
    apb(1'b1, 12'h428, 32'h1);
    // frozen clock enable: an ecc pulse must leave no trace
    clk_en <= 1'b0;
    pulse(6'h00, 1'b1);
    clk_en <= 1'b1;
    expect_state(st(1, 0, 0, 1));
    // user mode: no halt, fill ignored, back to dma on done
    rd_en <= 1'b0;
    apb(1'b1, 12'h404, {19'h0, 5'h03, 3'h0, 5'h05});
    pulse(6'h30, 1'b0);
    pulse(6'h00, 1'b1);
    expect_state(st(1, 0, 0, 1));
    apb(1'b1, 12'h424, 32'h1);
    expect_state(st(1, 0, 0, 1));
    pulse(6'h01, 1'b0);
    apb(1'b1, 12'h424, 32'h1);
    expect_state(st(0, 0, 0, 1));
    give_verdict;
  end
endmodule
